// File: rtl/vacuum_switch_point_monitor.sv
// Vacuum switch point evaluation with condition monitoring.
//
// Behaviour
// - Warnings held as bits 1, 3, 5.
// - Any warning but supply turns status light yellow immediately.
// - Evacuation over limit sets bit, yellow, event.
// - Zero limit disables check; writes above 9999 rejected.
// - Evacuation limit held in its own parameter.
// - Upper point missed sets warning, yellow.
// - Miss warning shown at phase end until cycle.
// - Upper point thresholds in two parameters.
// - Supply voltage measured and readable.
// - Supply out of band: warning, status, event, error.
// - Warnings and errors pushed as events.
// - Two points, four modes each, NO/NC variants.
// - NC inverts output, process bit, indicator.
// - Only one point in monitoring/diagnostics mode.
// - Two-point: on at threshold, off below reset.
// - Window active between limits, symmetric hysteresis.
// - Window limits share two-point threshold storage.
// - Reject mode change below 30 mbar separation.
// - Evacuation time in ms, lower to upper.
// - Suction cycle starts at apply-vacuum command.
`timescale 1ns/1ps
module vacuum_switch_point_monitor
  import vac_monitor_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS  = CYC_PER_MS,
  parameter logic [15:0] SUPPLY_TOL_MV  = 16'h0960
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        apply_vacuum,
  input  wire logic        vac_valid,
  input  wire logic [15:0] vac_sample,
  input  wire logic        supply_valid,
  input  wire logic [15:0] supply_mv,
  input  wire logic        par_wr,
  input  wire logic        par_rd,
  input  wire logic [7:0]  par_index,
  input  wire logic [15:0] par_wdata,
  output logic [15:0]      par_rdata_r,
  output logic             par_ack_r,
  output logic             par_err_r,
  output logic [1:0]       sw_out_r,
  output logic [1:0]       pd_bit_r,
  output logic [1:0]       led_orange_r,
  output logic [1:0]       status_light_r,
  output logic             device_error_r,
  output logic             event_valid_r,
  output logic [15:0]      event_code_r
);

  typedef enum logic [3:0] {
    CYC_IDLE   = 4'h1,
    CYC_WAIT   = 4'h2,
    CYC_TIMING = 4'h4,
    CYC_DONE   = 4'h8
  } cycle_e;

  cycle_e      cyc_r;
  logic [15:0] thr_on_r  [2];
  logic [15:0] thr_off_r [2];
  logic [2:0]  mode_r    [2];
  logic [15:0] win_hyst_r;
  logic [15:0] evac_limit_r;
  logic [15:0] evac_time_r;
  logic [15:0] supply_r;
  logic [7:0]  flags_r;
  logic [7:0]  flags_nxt;
  logic [2:0]  pend_r;
  logic [1:0]  act_r;
  logic [1:0]  act_nxt;
  logic        av_meta_r;
  logic        av_sync_r;
  logic        av_prev_r;
  logic        upper_seen_r;
  logic        supply_bad_r;
  logic [31:0] ms_div_r;
  logic [15:0] ms_cnt_r;
  logic        ms_tick;
  logic        cyc_start;
  logic        phase_end;
  logic        mode_wr;
  logic        mode_sel;
  logic        mode_ok;
  logic [2:0]  other_mode;
  logic [16:0] sep_on;
  logic [16:0] sep_off;

  // Apply-vacuum pin passes two flip-flops before any use.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      av_meta_r <= 1'b0;
      av_sync_r <= 1'b0;
      av_prev_r <= 1'b0;
    end else begin
      av_meta_r <= apply_vacuum;
      av_sync_r <= av_meta_r;
      av_prev_r <= av_sync_r;
    end
  end

  assign cyc_start = av_sync_r & ~av_prev_r;
  assign phase_end = ~av_sync_r & av_prev_r;

  // Mode write validation against separation and exclusivity.
  assign mode_wr    = par_wr & ((par_index == IDX_UPPER_MODE) |
                                (par_index == IDX_LOWER_MODE));
  assign mode_sel   = (par_index == IDX_LOWER_MODE);
  assign other_mode = mode_sel ? mode_r[0] : mode_r[1];
  assign sep_on     = {1'b0, thr_off_r[mode_sel]} + MIN_SEP_MBAR;
  assign sep_off    = {1'b0, thr_off_r[mode_sel]} + {1'b0, win_hyst_r} +
                      MIN_SEP_MBAR;

  always_comb begin
    mode_ok = 1'b1;
    if (par_wdata[2] && other_mode[2]) begin
      mode_ok = 1'b0;
    end
    if ((par_wdata[2:1] == MODE_TWO_POINT) &&
        ({1'b0, thr_on_r[mode_sel]} < sep_on)) begin
      mode_ok = 1'b0;
    end
    if ((par_wdata[2:1] == MODE_WINDOW) &&
        ({1'b0, thr_on_r[mode_sel]} < sep_off)) begin
      mode_ok = 1'b0;
    end
  end

  // Parameter writes; threshold storage is shared by both modes.
  // shared limit storage
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < 2; i++) begin
        thr_on_r[i]  <= RESET_ZERO;
        thr_off_r[i] <= RESET_ZERO;
        mode_r[i]    <= MODE_RESET;
      end
      win_hyst_r   <= RESET_ZERO;
      evac_limit_r <= RESET_ZERO;
    end else if (par_wr) begin
      case (par_index)
        IDX_UPPER_THR_A: thr_on_r[0]  <= par_wdata;
        IDX_UPPER_THR_B: thr_off_r[0] <= par_wdata;
        IDX_LOWER_THR_A: thr_on_r[1]  <= par_wdata;
        IDX_LOWER_THR_B: thr_off_r[1] <= par_wdata;
        IDX_WIN_HYST:    win_hyst_r   <= par_wdata;
        IDX_EVAC_LIMIT: begin
          if (par_wdata <= MAX_EVAC_MS) begin
            evac_limit_r <= par_wdata;
          end
        end
        IDX_UPPER_MODE: begin
          if (mode_ok) begin
            mode_r[0] <= par_wdata[2:0];
          end
        end
        IDX_LOWER_MODE: begin
          if (mode_ok) begin
            mode_r[1] <= par_wdata[2:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Parameter reads and the acknowledge of every access.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      par_rdata_r <= RESET_ZERO;
      par_ack_r   <= 1'b0;
      par_err_r   <= 1'b0;
    end else begin
      par_ack_r <= par_wr | par_rd;
      par_err_r <= 1'b0;
      if (par_rd) begin
        case (par_index)
          IDX_UPPER_THR_A: par_rdata_r <= thr_on_r[0];
          IDX_UPPER_THR_B: par_rdata_r <= thr_off_r[0];
          IDX_LOWER_THR_A: par_rdata_r <= thr_on_r[1];
          IDX_LOWER_THR_B: par_rdata_r <= thr_off_r[1];
          IDX_UPPER_MODE:  par_rdata_r <= {13'h0000, mode_r[0]};
          IDX_LOWER_MODE:  par_rdata_r <= {13'h0000, mode_r[1]};
          IDX_SUPPLY_VOLT: par_rdata_r <= supply_r;
          IDX_WIN_HYST:    par_rdata_r <= win_hyst_r;
          IDX_EVAC_LIMIT:  par_rdata_r <= evac_limit_r;
          IDX_COND_FLAGS:  par_rdata_r <= {8'h00, flags_r};
          IDX_EVAC_TIME:   par_rdata_r <= evac_time_r;
          default: begin
            par_rdata_r <= RESET_ZERO;
            par_err_r   <= 1'b1;
          end
        endcase
      end else if (par_wr) begin
        par_err_r <= (mode_wr & ~mode_ok) |
                     ((par_index == IDX_EVAC_LIMIT) &
                      (par_wdata > MAX_EVAC_MS));
      end
    end
  end

  // Per-point evaluation against the newest sample.
  for (genvar g = 0; g < 2; g++) begin : g_point
    logic [16:0] samp;
    logic [16:0] hi;
    logic [16:0] lo;
    logic [16:0] hy;
    assign samp = {1'b0, vac_sample};
    assign hi   = {1'b0, thr_on_r[g]};
    assign lo   = {1'b0, thr_off_r[g]};
    assign hy   = {1'b0, win_hyst_r};

    always_comb begin
      act_nxt[g] = act_r[g];
      if (vac_valid) begin
        case (mode_r[g][2:1])
          MODE_TWO_POINT: begin
            if (samp >= hi) begin
              act_nxt[g] = 1'b1;
            end else if (samp < lo) begin
              act_nxt[g] = 1'b0;
            end
          end
          MODE_WINDOW: begin
            if (act_r[g]) begin
              act_nxt[g] = (samp + hy >= lo) && (samp <= hi + hy);
            end else begin
              act_nxt[g] = (samp >= lo + hy) && (samp + hy <= hi);
            end
          end
          default: act_nxt[g] = 1'b0;
        endcase
      end
    end

    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        act_r[g]        <= 1'b0;
        sw_out_r[g]     <= 1'b0;
        pd_bit_r[g]     <= 1'b0;
        led_orange_r[g] <= 1'b0;
      end else begin
        act_r[g]        <= act_nxt[g];
        sw_out_r[g]     <= act_r[g] ^ mode_r[g][0];
        pd_bit_r[g]     <= act_r[g] ^ mode_r[g][0];
        led_orange_r[g] <= act_r[g] ^ mode_r[g][0];
      end
    end
  end

  // Millisecond tick for evacuation timing.
  assign ms_tick = (ms_div_r == CYCLES_PER_MS - 1);
  always_ff @(posedge clk_sys) begin
    if (sys_rst || ms_tick || cyc_r != CYC_TIMING) begin
      ms_div_r <= 32'h00000000;
    end else begin
      ms_div_r <= ms_div_r + 32'h00000001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cyc_r        <= CYC_IDLE;
      ms_cnt_r     <= RESET_ZERO;
      evac_time_r  <= RESET_ZERO;
      upper_seen_r <= 1'b0;
    end else begin
      if (act_r[0] && cyc_r != CYC_IDLE) begin
        upper_seen_r <= 1'b1;
      end
      case (cyc_r)
        CYC_IDLE: ;
        CYC_WAIT: begin
          if (act_r[1]) begin
            cyc_r    <= CYC_TIMING;
            ms_cnt_r <= RESET_ZERO;
          end
        end
        CYC_TIMING: begin
          if (act_r[0]) begin
            cyc_r       <= CYC_DONE;
            evac_time_r <= ms_cnt_r;
          end else if (ms_tick && ms_cnt_r != 16'hffff) begin
            ms_cnt_r <= ms_cnt_r + 16'h0001;
          end
        end
        CYC_DONE: ;
        default: cyc_r <= CYC_IDLE;
      endcase
      if (phase_end) begin
        cyc_r <= CYC_IDLE;
      end
      if (cyc_start) begin
        cyc_r        <= CYC_WAIT;
        upper_seen_r <= 1'b0;
      end
    end
  end

  // Supply voltage capture and tolerance band check.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      supply_r     <= RESET_ZERO;
      supply_bad_r <= 1'b0;
    end else if (supply_valid) begin
      supply_r     <= supply_mv;
      supply_bad_r <= ({1'b0, supply_mv} >
                       {1'b0, SUPPLY_NOM_MV} + {1'b0, SUPPLY_TOL_MV}) ||
                      ({1'b0, supply_mv} + {1'b0, SUPPLY_TOL_MV} <
                       {1'b0, SUPPLY_NOM_MV});
    end
  end

  // Warning flags; a set in the cycle-start cycle wins over the clear.
  always_comb begin
    flags_nxt = flags_r;
    if (cyc_start) begin
      flags_nxt[BIT_EVAC_OVER]  = 1'b0;
      flags_nxt[BIT_UPPER_MISS] = 1'b0;
    end
    if (cyc_r == CYC_TIMING && evac_limit_r != RESET_ZERO &&
        ms_cnt_r > evac_limit_r) begin
      flags_nxt[BIT_EVAC_OVER] = 1'b1;
    end
    if (phase_end && !upper_seen_r && !act_r[0]) begin
      flags_nxt[BIT_UPPER_MISS] = 1'b1;
    end
    flags_nxt[BIT_SUPPLY_BAD] = supply_bad_r;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_r        <= 8'h00;
      status_light_r <= LIGHT_GREEN;
      device_error_r <= 1'b0;
    end else begin
      flags_r        <= flags_nxt;
      device_error_r <= flags_nxt[BIT_SUPPLY_BAD];
      if (flags_nxt[BIT_SUPPLY_BAD]) begin
        status_light_r <= LIGHT_RED;
      end else if (flags_nxt != 8'h00) begin
        status_light_r <= LIGHT_YELLOW;
      end else begin
        status_light_r <= LIGHT_GREEN;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pend_r        <= 3'h0;
      event_valid_r <= 1'b0;
      event_code_r  <= RESET_ZERO;
    end else begin
      event_valid_r <= 1'b0;
      if (pend_r[0]) begin
        event_valid_r <= 1'b1;
        event_code_r  <= EVT_EVAC_OVER;
      end else if (pend_r[1]) begin
        event_valid_r <= 1'b1;
        event_code_r  <= EVT_UPPER_MISS;
      end else if (pend_r[2]) begin
        event_valid_r <= 1'b1;
        event_code_r  <= EVT_SUPPLY_BAD;
      end
      pend_r <= (pend_r & ~(pend_r & (~pend_r + 3'h1))) |
                {flags_nxt[BIT_SUPPLY_BAD] & ~flags_r[BIT_SUPPLY_BAD],
                 flags_nxt[BIT_UPPER_MISS] & ~flags_r[BIT_UPPER_MISS],
                 flags_nxt[BIT_EVAC_OVER] & ~flags_r[BIT_EVAC_OVER]};
    end
  end

  a_evac_disabled: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (evac_limit_r == RESET_ZERO) |=> !$rose(flags_r[BIT_EVAC_OVER]))
    else $error("evacuation warning with zero limit");
  a_light_yellow: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (flags_r != 8'h00 && !flags_r[BIT_SUPPLY_BAD]) |->
    status_light_r == LIGHT_YELLOW)
    else $error("warning present but light not yellow");
  a_event_follows: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(flags_r[BIT_EVAC_OVER]) |-> ##[0:3]
    (event_valid_r && event_code_r == EVT_EVAC_OVER))
    else $error("no event for evacuation warning");
  a_nc_invert: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ##1 sw_out_r[0] == ($past(act_r[0]) ^ $past(mode_r[0][0])) &&
    pd_bit_r == sw_out_r && led_orange_r == sw_out_r)
    else $error("output logic inversion wrong");
  a_mode_excl: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(mode_r[0][2] && mode_r[1][2]))
    else $error("both points in monitoring mode");
  // miss appears only at phase end
  a_miss_phase: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(flags_r[BIT_UPPER_MISS]) |-> $past(phase_end))
    else $error("miss warning outside phase end");
  a_reject_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (mode_wr && !mode_ok && !mode_sel) |=> $stable(mode_r[0]) && par_err_r)
    else $error("rejected mode change altered mode");
  a_supply_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (supply_valid && ({1'b0, supply_mv} >
     {1'b0, SUPPLY_NOM_MV} + {1'b0, SUPPLY_TOL_MV})) |=> ##1
    (flags_r[BIT_SUPPLY_BAD] && status_light_r == LIGHT_RED))
    else $error("supply fault not flagged");
  a_two_point_on: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (vac_valid && mode_r[0][2:1] == MODE_TWO_POINT &&
     vac_sample >= thr_on_r[0]) |=> act_r[0])
    else $error("two-point did not switch on");

endmodule // vacuum_switch_point_monitor

// File: rtl/vac_monitor_pkg.sv
// Shared constants for the vacuum switch point monitor.
package vac_monitor_pkg;
  // Parameter indices reached over the parameter access port.
  localparam logic [7:0] IDX_UPPER_THR_A  = 8'h3c;
  localparam logic [7:0] IDX_UPPER_THR_B  = 8'h3d;
  localparam logic [7:0] IDX_LOWER_THR_A  = 8'h3e;
  localparam logic [7:0] IDX_LOWER_THR_B  = 8'h3f;
  localparam logic [7:0] IDX_UPPER_MODE   = 8'h40;
  localparam logic [7:0] IDX_LOWER_MODE   = 8'h41;
  localparam logic [7:0] IDX_SUPPLY_VOLT  = 8'h42;
  localparam logic [7:0] IDX_WIN_HYST     = 8'h43;
  localparam logic [7:0] IDX_EVAC_LIMIT   = 8'h6b;
  localparam logic [7:0] IDX_COND_FLAGS   = 8'h92;
  localparam logic [7:0] IDX_EVAC_TIME    = 8'h95;
  // Bit positions of the condition warning flags.
  localparam int unsigned BIT_EVAC_OVER   = 1;
  localparam int unsigned BIT_UPPER_MISS  = 3;
  localparam int unsigned BIT_SUPPLY_BAD  = 5;
  // Switching point mode field: bits 2:1 select the mode, bit 0 selects NC.
  localparam logic [1:0] MODE_TWO_POINT   = 2'h0;
  localparam logic [1:0] MODE_WINDOW      = 2'h1;
  localparam logic [1:0] MODE_COND_MON    = 2'h2;
  localparam logic [1:0] MODE_DIAG        = 2'h3;
  localparam logic [2:0] MODE_RESET       = 3'h0;
  // Status light codes.
  localparam logic [1:0] LIGHT_GREEN      = 2'h0;
  localparam logic [1:0] LIGHT_YELLOW     = 2'h1;
  localparam logic [1:0] LIGHT_RED        = 2'h2;
  // Event codes, values are arbitrary.
  localparam logic [15:0] EVT_EVAC_OVER   = 16'h0a01;
  localparam logic [15:0] EVT_UPPER_MISS  = 16'h0a03;
  localparam logic [15:0] EVT_SUPPLY_BAD  = 16'h0a05;
  // Limits and figures.
  localparam logic [16:0] MIN_SEP_MBAR    = 17'h0001e;
  localparam logic [15:0] MAX_EVAC_MS     = 16'h270f;
  localparam logic [15:0] SUPPLY_NOM_MV   = 16'h5dc0;
  localparam logic [15:0] RESET_ZERO      = 16'h0000;
  // Timing: one millisecond expressed in clock cycles.
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned MS_IN_NS        = 1000000;
  localparam int unsigned CYC_PER_MS      = MS_IN_NS / CLK_PERIOD_NS;
endpackage

// File: testbench/iolink_master_model.sv
// Parameter access master that stands in for the IO-Link master.
`timescale 1ns/1ps
module iolink_master_model (
  input  wire logic        clk_sys,
  output logic             par_wr,
  output logic             par_rd,
  output logic [7:0]       par_index,
  output logic [15:0]      par_wdata
);
  // Idle strobes are low and the address lines carry a pattern.
  initial begin
    par_wr    = 1'b0;
    par_rd    = 1'b0;
    par_index = 8'h5a;
    par_wdata = 16'ha5c3;
  end

  // One strobed request, held over exactly one rising edge.
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [15:0] d);
    @(negedge clk_sys);
    par_wr    = wr;
    par_rd    = ~wr;
    par_index = idx;
    par_wdata = d;
    @(negedge clk_sys);
    par_wr    = 1'b0;
    par_rd    = 1'b0;
    // Released lines are inverted so a stale value never looks valid.
    par_index = ~idx;
    par_wdata = ~d;
  endtask
endmodule // iolink_master_model

// File: testbench/vacuum_switch_point_monitor_bench.sv
// Self-checking bench for the vacuum switch point monitor.
`timescale 1ns/1ps
module vacuum_switch_point_monitor_bench;
  import vac_monitor_pkg::*;
  localparam int unsigned CPM = 10;
  logic        clk_sys, sys_rst, apply_vacuum, vac_valid, supply_valid;
  logic        par_wr, par_rd, par_ack_r, par_err_r;
  logic        device_error_r, event_valid_r;
  logic [7:0]  par_index;
  logic [15:0] vac_sample, supply_mv, par_wdata, par_rdata_r;
  logic [15:0] event_code_r, e;
  logic [1:0]  sw_out_r, pd_bit_r, led_orange_r, status_light_r;
  logic [17:0] ans_q[$];
  logic [15:0] ev_q[$];
  logic [17:0] a;
  logic [31:0] r;
  int          failures, check_count, cycles;
  integer      seed;

  // Free running clock of 4 ns.
  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;

  vacuum_switch_point_monitor #(.CYCLES_PER_MS(CPM)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .apply_vacuum(apply_vacuum),
    .vac_valid(vac_valid), .vac_sample(vac_sample),
    .supply_valid(supply_valid), .supply_mv(supply_mv),
    .par_wr(par_wr), .par_rd(par_rd), .par_index(par_index),
    .par_wdata(par_wdata), .par_rdata_r(par_rdata_r),
    .par_ack_r(par_ack_r), .par_err_r(par_err_r), .sw_out_r(sw_out_r),
    .pd_bit_r(pd_bit_r), .led_orange_r(led_orange_r),
    .status_light_r(status_light_r), .device_error_r(device_error_r),
    .event_valid_r(event_valid_r), .event_code_r(event_code_r));

  iolink_master_model master (
    .clk_sys(clk_sys), .par_wr(par_wr), .par_rd(par_rd),
    .par_index(par_index), .par_wdata(par_wdata));

  // Counts comparisons and reports a mismatch at once.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t ns: saw %h expected %h", $time, seen,
               exp);
    end
  endtask

  // Prints the verdict and stops the run.
  task automatic end_of_test();
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Notes the expected answer, then issues the request.
  task automatic acc(input logic wr, input logic [7:0] idx,
                     input logic [15:0] d, input logic er,
                     input logic [15:0] x);
    ans_q.push_back({~wr, er, x});
    master.xfer(wr, idx, d);
  endtask

  // Sends one vacuum sample and checks the upper point two cycles on.
  task automatic samp(input logic [15:0] v, input logic x);
    @(negedge clk_sys);
    vac_sample = v;
    vac_valid  = 1'b1;
    @(negedge clk_sys);
    vac_valid  = 1'b0;
    vac_sample = ~v;
    repeat (2) @(negedge clk_sys);
    chk({15'h0, sw_out_r[0]}, {15'h0, x});
    chk({14'h0, pd_bit_r[0], led_orange_r[0]}, {14'h0, x, x});
  endtask

  // Sends one supply reading and checks error level and light.
  task automatic supply(input logic [15:0] mv, input logic bad);
    @(negedge clk_sys);
    supply_mv    = mv;
    supply_valid = 1'b1;
    @(negedge clk_sys);
    supply_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk({15'h0, device_error_r}, {15'h0, bad});
    chk({14'h0, status_light_r}, {14'h0, bad ? LIGHT_RED : LIGHT_GREEN});
  endtask

  // Starts or ends a suction cycle and lets the pin synchroniser settle.
  task automatic suction(input logic on);
    @(negedge clk_sys);
    apply_vacuum = on;
    repeat (6) @(negedge clk_sys);
  endtask

  // Takes the oldest noted answer or event whenever one appears.
  always @(negedge clk_sys) begin
    if (par_ack_r === 1'b1) begin
      a = (ans_q.size() > 0) ? ans_q.pop_front() : 18'h2ffff;
      chk({15'h0, par_err_r}, {15'h0, a[16]});
      if (a[17] && !a[16]) begin
        chk(par_rdata_r, a[15:0]);
      end
    end
    if (event_valid_r === 1'b1) begin
      e = (ev_q.size() > 0) ? ev_q.pop_front() : 16'hffff;
      chk(event_code_r, e);
    end
  end

  // Cuts a hang short.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end

  // Main sequence.
  initial begin
    seed         = 32'h1039;
    failures     = 0;
    check_count  = 0;
    cycles       = 0;
    sys_rst      = 1'b1;
    apply_vacuum = 1'b0;
    vac_valid    = 1'b0;
    vac_sample   = 16'h0000;
    supply_valid = 1'b0;
    supply_mv    = SUPPLY_NOM_MV;
    repeat (10) @(negedge clk_sys);
    sys_rst = 1'b0;
    acc(1'b0, IDX_UPPER_THR_A, 16'h0, 1'b0, 16'h0);
    acc(1'b0, IDX_EVAC_LIMIT, 16'h0, 1'b0, 16'h0);
    acc(1'b0, IDX_COND_FLAGS, 16'h0, 1'b0, 16'h0);
    acc(1'b0, 8'h00, 16'h0, 1'b1, 16'h0);
    r = $random(seed);
    acc(1'b1, IDX_UPPER_THR_B, r[15:0], 1'b0, 16'h0);
    acc(1'b0, IDX_UPPER_THR_B, 16'h0, 1'b0, r[15:0]);
    acc(1'b1, IDX_EVAC_LIMIT, MAX_EVAC_MS, 1'b0, 16'h0);
    acc(1'b1, IDX_EVAC_LIMIT, 16'h2710, 1'b1, 16'h0);
    acc(1'b0, IDX_EVAC_LIMIT, 16'h0, 1'b0, MAX_EVAC_MS);
    // Switch-on kept above reset by at least 30 mbar.
    // host threshold order
    acc(1'b1, IDX_UPPER_THR_A, 16'h00c8, 1'b0, 16'h0);
    acc(1'b1, IDX_UPPER_THR_B, 16'h0064, 1'b0, 16'h0);
    acc(1'b1, IDX_LOWER_THR_A, 16'h0064, 1'b0, 16'h0);
    acc(1'b1, IDX_LOWER_THR_B, 16'h0032, 1'b0, 16'h0);
    samp(16'h00c7, 1'b0);
    samp(16'h00c8, 1'b1);
    samp(16'h0064, 1'b1);
    samp(16'h0063, 1'b0);
    acc(1'b1, IDX_UPPER_MODE, 16'h0001, 1'b0, 16'h0);
    samp(16'h00fa, 1'b0);
    chk({13'h0, sw_out_r[1], pd_bit_r[1], led_orange_r[1]}, 16'h0007);
    samp(16'h0000, 1'b1);
    chk({13'h0, sw_out_r[1], pd_bit_r[1], led_orange_r[1]}, 16'h0000);
    acc(1'b1, IDX_WIN_HYST, 16'h0064, 1'b0, 16'h0);
    acc(1'b1, IDX_UPPER_MODE, 16'h0002, 1'b1, 16'h0);
    acc(1'b0, IDX_UPPER_MODE, 16'h0, 1'b0, 16'h0001);
    // Window hysteresis small enough for the stored limits.
    // host window order
    acc(1'b1, IDX_WIN_HYST, 16'h000a, 1'b0, 16'h0);
    acc(1'b1, IDX_UPPER_MODE, 16'h0002, 1'b0, 16'h0);
    samp(16'h0096, 1'b1);
    samp(16'h00cd, 1'b1);
    samp(16'h00d7, 1'b0);
    acc(1'b1, IDX_UPPER_MODE, 16'h0005, 1'b0, 16'h0);
    samp(16'h00fa, 1'b1);
    acc(1'b1, IDX_LOWER_MODE, 16'h0006, 1'b1, 16'h0);
    acc(1'b0, IDX_LOWER_MODE, 16'h0, 1'b0, 16'h0);
    acc(1'b1, IDX_UPPER_MODE, 16'h0000, 1'b0, 16'h0);
    acc(1'b1, IDX_LOWER_MODE, 16'h0007, 1'b0, 16'h0);
    acc(1'b1, IDX_LOWER_MODE, 16'h0000, 1'b0, 16'h0);
    r = $random(seed);
    supply(SUPPLY_NOM_MV - 16'h0400 + {5'h0, r[10:0]}, 1'b0);
    ev_q.push_back(EVT_SUPPLY_BAD);
    supply(16'h7530, 1'b1);
    acc(1'b0, IDX_SUPPLY_VOLT, 16'h0, 1'b0, 16'h7530);
    acc(1'b0, IDX_COND_FLAGS, 16'h0, 1'b0, 16'h0020);
    supply(SUPPLY_NOM_MV, 1'b0);
    acc(1'b1, IDX_EVAC_LIMIT, 16'h0003, 1'b0, 16'h0);
    samp(16'h0000, 1'b0);
    suction(1'b1);
    samp(16'h0078, 1'b0);
    ev_q.push_back(EVT_EVAC_OVER);
    repeat (60) @(negedge clk_sys);
    chk({14'h0, status_light_r}, {14'h0, LIGHT_YELLOW});
    samp(16'h015e, 1'b1);
    // Lower point active to upper point active spans 64 cycles: 6 whole ms.
    acc(1'b0, IDX_EVAC_TIME, 16'h0, 1'b0, 16'h0006);
    acc(1'b0, IDX_COND_FLAGS, 16'h0, 1'b0, 16'h0002);
    suction(1'b0);
    acc(1'b0, IDX_COND_FLAGS, 16'h0, 1'b0, 16'h0002);
    acc(1'b1, IDX_EVAC_LIMIT, 16'h0000, 1'b0, 16'h0);
    samp(16'h0000, 1'b0);
    suction(1'b1);
    acc(1'b0, IDX_COND_FLAGS, 16'h0, 1'b0, 16'h0000);
    samp(16'h0078, 1'b0);
    repeat (60) @(negedge clk_sys);
    acc(1'b0, IDX_COND_FLAGS, 16'h0, 1'b0, 16'h0000);
    chk({14'h0, status_light_r}, {14'h0, LIGHT_GREEN});
    ev_q.push_back(EVT_UPPER_MISS);
    suction(1'b0);
    acc(1'b0, IDX_COND_FLAGS, 16'h0, 1'b0, 16'h0008);
    chk({14'h0, status_light_r}, {14'h0, LIGHT_YELLOW});
    repeat (20) @(negedge clk_sys);
    acc(1'b0, IDX_COND_FLAGS, 16'h0, 1'b0, 16'h0008);
    suction(1'b1);
    acc(1'b0, IDX_COND_FLAGS, 16'h0, 1'b0, 16'h0000);
    repeat (10) @(negedge clk_sys);
    chk(16'(ev_q.size()), 16'h0);
    chk(16'(ans_q.size()), 16'h0);
    end_of_test();
  end
endmodule // vacuum_switch_point_monitor_bench
